// File: rtl/pca_cfg_pkg.sv
/*
 Constants for the counter array mode and PWM configuration registers.
 Assumes an 8-bit special function register bus with one-cycle writes.
*/
package pca_cfg_pkg;
	// ==========================================
	// Register addresses
	localparam logic [7:0] ADDR_MODE_CTRL = 8'hd9;
	localparam logic [7:0] ADDR_PWM_CFG = 8'hdf;
	// ==========================================
	// Mode register fields
	localparam int MD_IDLE_SUSPEND = 7;
	localparam int MD_WD_ENABLE = 6;
	localparam int MD_WD_LOCK = 5;
	localparam int MD_TB_LSB = 1;
	localparam int MD_WRAP_IRQ_EN = 0;
	localparam logic [7:0] MODE_RESET = 8'h40;
	// ==========================================
	// PWM register fields
	localparam int PW_BANK_SEL = 7;
	localparam int PW_WRAP_IRQ_EN = 6;
	localparam int PW_WRAP_FLAG = 5;
	localparam int PW_LEN_LSB = 0;
	localparam logic [7:0] PWM_RESET = 8'h00;
	localparam logic [2:0] UNUSED_READ = 3'h0;
	// ==========================================
	// Timebase sources
	typedef enum logic [2:0] {
		TB_SYS_DIV12 = 3'h0,
		TB_SYS_DIV4 = 3'h1,
		TB_TIMER0_OVF = 3'h2,
		TB_EXT_FALL = 3'h3,
		TB_SYS = 3'h4,
		TB_EXT_DIV8 = 3'h5
	} timebase_t;
	// Cycle lengths
	typedef enum logic [1:0] {
		LEN_8 = 2'h0,
		LEN_9 = 2'h1,
		LEN_10 = 2'h2,
		LEN_11 = 2'h3
	} cycle_len_t;
	// Counter bit positions whose carry marks a cycle wrap
	localparam int WRAP_BIT_8 = 7;
endpackage

// File: rtl/pca_mode_pwm_config.sv
/*
 Mode and PWM configuration registers of the programmable counter array.
 Assumes the CPU register bus is synchronous to i_clk and the counter core
 reports carries out of counter bits 7..10 as one-cycle pulses.
*/
`timescale 1ns/1ns
module pca_mode_pwm_config #(
	parameter int CHANNELS = 6
)
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [7:0] i_addr,
	input wire logic i_wr,
	input wire logic [7:0] i_wdata,
	input wire logic i_rd,
	input wire logic [3:0] i_carry,
	input wire logic i_cpu_idle,
	input wire logic [CHANNELS-1:0] i_pwm16,
	input wire logic [CHANNELS-1:0] i_pwm_mode,
	output logic [7:0] o_rdata,
	output logic o_irq,
	output logic o_reload_bank_select,
	output logic [CHANNELS-1:0] o_reload_active,
	output logic [1:0] o_cycle_length_select,
	output logic o_counter_halt,
	output logic o_watchdog_enable,
	output logic [2:0] o_counter_timebase_select,
	output logic o_counter_wrap_irq_enable
);
	// ==========================================
	// Register state
	logic idle_suspend_q, idle_suspend_d;
	logic watchdog_enable_q, watchdog_enable_d;
	logic watchdog_lock_q, watchdog_lock_d;
	logic [2:0] timebase_q, timebase_d;
	logic wrap_irq_en_q, wrap_irq_en_d;
	logic bank_sel_q, bank_sel_d;
	logic cycle_irq_en_q, cycle_irq_en_d;
	logic wrap_flag_q, wrap_flag_d;
	logic [1:0] len_q, len_d;
	logic [7:0] rdata_d;
	logic [CHANNELS-1:0] reload_active_d;

	// ==========================================
	// Decode
	// Register address match, shared by the write strobes and the read mux
	function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] reg_addr);
		return addr == reg_addr;
	endfunction

	wire rd_mode = i_rd && addr_hit(i_addr, pca_cfg_pkg::ADDR_MODE_CTRL);
	wire rd_pwm = i_rd && addr_hit(i_addr, pca_cfg_pkg::ADDR_PWM_CFG);
	wire wr_mode = i_wr && addr_hit(i_addr, pca_cfg_pkg::ADDR_MODE_CTRL);
	wire wr_pwm = i_wr && addr_hit(i_addr, pca_cfg_pkg::ADDR_PWM_CFG);
	wire wd_on = watchdog_enable_q || watchdog_lock_q;
	wire [7:0] mode_rd = {idle_suspend_q, wd_on, watchdog_lock_q, 1'b0, timebase_q, wrap_irq_en_q};
	wire [7:0] pwm_rd = {bank_sel_q, cycle_irq_en_q, wrap_flag_q,
		pca_cfg_pkg::UNUSED_READ, len_q};
	// Selected carry: code 0..3 maps to counter bits 7..10
	wire wrap_event = i_carry[len_q];

	// Mode register; watchdog state freezes timebase and idle suspend
	assign watchdog_enable_d = wr_mode ? (i_wdata[pca_cfg_pkg::MD_WD_ENABLE] || watchdog_lock_q)
		: watchdog_enable_q;
	// Lock is only ever set by software, only reset clears it
	assign watchdog_lock_d = watchdog_lock_q || (wr_mode && i_wdata[pca_cfg_pkg::MD_WD_LOCK]);
	assign idle_suspend_d = (wr_mode && !wd_on) ? i_wdata[pca_cfg_pkg::MD_IDLE_SUSPEND]
		: idle_suspend_q;
	assign timebase_d = (wr_mode && !wd_on) ? i_wdata[pca_cfg_pkg::MD_TB_LSB +: 3]
		: timebase_q;
	assign wrap_irq_en_d = wr_mode ? i_wdata[pca_cfg_pkg::MD_WRAP_IRQ_EN] : wrap_irq_en_q;

	// PWM register
	assign bank_sel_d = wr_pwm ? i_wdata[pca_cfg_pkg::PW_BANK_SEL] : bank_sel_q;
	assign cycle_irq_en_d = wr_pwm ? i_wdata[pca_cfg_pkg::PW_WRAP_IRQ_EN] : cycle_irq_en_q;
	assign len_d = wr_pwm ? i_wdata[pca_cfg_pkg::PW_LEN_LSB +: 2] : len_q;
	// Hardware set wins over a software clear in the same cycle
	assign wrap_flag_d = wrap_event ? 1'b1
		: (wr_pwm ? i_wdata[pca_cfg_pkg::PW_WRAP_FLAG] : wrap_flag_q);

	// Reload value only matters for 9 to 11-bit cycles on channels in PWM mode that are not 16-bit
	assign reload_active_d = (len_q != pca_cfg_pkg::LEN_8) ? (i_pwm_mode & ~i_pwm16)
		: {CHANNELS{1'b0}};
	// Idle cycles and unmapped addresses read as zero
	assign rdata_d = rd_mode ? mode_rd
		: rd_pwm ? pwm_rd : 8'h00;

	// ==========================================
	// Mode register state
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			idle_suspend_q <= pca_cfg_pkg::MODE_RESET[pca_cfg_pkg::MD_IDLE_SUSPEND];
		else
			idle_suspend_q <= idle_suspend_d;
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			watchdog_enable_q <= pca_cfg_pkg::MODE_RESET[pca_cfg_pkg::MD_WD_ENABLE];
		else
			watchdog_enable_q <= watchdog_enable_d;
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			watchdog_lock_q <= pca_cfg_pkg::MODE_RESET[pca_cfg_pkg::MD_WD_LOCK];
		else
			watchdog_lock_q <= watchdog_lock_d;
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			timebase_q <= pca_cfg_pkg::TB_SYS_DIV12;
		else
			timebase_q <= timebase_d;
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			wrap_irq_en_q <= pca_cfg_pkg::MODE_RESET[pca_cfg_pkg::MD_WRAP_IRQ_EN];
		else
			wrap_irq_en_q <= wrap_irq_en_d;
	end

	// ==========================================
	// PWM register state
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			bank_sel_q <= pca_cfg_pkg::PWM_RESET[pca_cfg_pkg::PW_BANK_SEL];
		else
			bank_sel_q <= bank_sel_d;
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			cycle_irq_en_q <= pca_cfg_pkg::PWM_RESET[pca_cfg_pkg::PW_WRAP_IRQ_EN];
		else
			cycle_irq_en_q <= cycle_irq_en_d;
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			wrap_flag_q <= pca_cfg_pkg::PWM_RESET[pca_cfg_pkg::PW_WRAP_FLAG];
		else
			wrap_flag_q <= wrap_flag_d;
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			len_q <= pca_cfg_pkg::LEN_8;
		else
			len_q <= len_d;
	end

	// ==========================================
	// Outputs
	// Outputs are registered copies or gated combinations of the state, so they trail it by one cycle
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			o_rdata <= 8'h00;
		else
			o_rdata <= rdata_d;
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			o_irq <= 1'b0;
		else
			o_irq <= wrap_flag_q && cycle_irq_en_q;
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			o_reload_bank_select <= pca_cfg_pkg::PWM_RESET[pca_cfg_pkg::PW_BANK_SEL];
		else
			o_reload_bank_select <= bank_sel_q;
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			o_reload_active <= '0;
		else
			o_reload_active <= reload_active_d;
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			o_cycle_length_select <= pca_cfg_pkg::LEN_8;
		else
			o_cycle_length_select <= len_q;
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			o_counter_halt <= pca_cfg_pkg::MODE_RESET[pca_cfg_pkg::MD_IDLE_SUSPEND];
		else
			o_counter_halt <= idle_suspend_q && i_cpu_idle;
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			o_watchdog_enable <= pca_cfg_pkg::MODE_RESET[pca_cfg_pkg::MD_WD_ENABLE];
		else
			o_watchdog_enable <= wd_on;
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			o_counter_timebase_select <= pca_cfg_pkg::TB_SYS_DIV12;
		else
			o_counter_timebase_select <= timebase_q;
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			o_counter_wrap_irq_enable <= pca_cfg_pkg::MODE_RESET[pca_cfg_pkg::MD_WRAP_IRQ_EN];
		else
			o_counter_wrap_irq_enable <= wrap_irq_en_q;
	end
endmodule // pca_mode_pwm_config

// File: testbench/pca_cfg_asserts.sv
/* Port-level checks for the mode and pwm configuration block.
 Assumes it is bound onto the block and that the bench exercises each case. */
`timescale 1ns/1ns
module pca_cfg_chk #(parameter int CHANNELS = 6)
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic i_cpu_idle,
	input wire logic o_irq,
	input wire logic o_counter_halt,
	input wire logic o_watchdog_enable,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic [7:0] o_rdata,
	input wire logic [CHANNELS-1:0] i_pwm16,
	input wire logic [CHANNELS-1:0] i_pwm_mode,
	input wire logic [CHANNELS-1:0] o_reload_active,
	input wire logic [1:0] o_cycle_length_select,
	input wire logic [2:0] o_counter_timebase_select
);
	// ======
	// Checks
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	wire logic wr_md = i_wr && i_addr == 8'hd9;
	wire logic wr_pw = i_wr && i_addr == 8'hdf;
	sequence lock_set; wr_md && i_wdata[5]; endsequence
	sequence irq_arm; wr_pw && i_wdata[6:5] == 2'h3; endsequence
	lock_keep_a: assert property (lock_set ##2 wr_md |-> ##2 o_watchdog_enable)
		else $error("lock lost");
	reload_mask_a: assert property (!$past(i_rst) |-> o_reload_active ==
		((o_cycle_length_select == 2'h0) ? {CHANNELS{1'b0}}
		: ($past(i_pwm_mode) & ~$past(i_pwm16)))) else $error("reload mask");
	halt_run_a: assert property (!i_cpu_idle |=> !o_counter_halt)
		else $error("halt outside idle");
	irq_on_a: assert property (irq_arm |-> ##2 o_irq) else $error("no irq");
	irq_mask_a: assert property (wr_pw && !i_wdata[6] |-> ##2 !o_irq)
		else $error("masked irq");
	unused_zero_a: assert property (i_rd && i_addr == 8'hdf |=> o_rdata[4:2] == 3'h0)
		else $error("unused bits");
	flag_stick_a: assert property (o_irq && !$past(wr_pw) |=> o_irq)
		else $error("flag cleared");
	tb_freeze_a: assert property (o_watchdog_enable && $past(o_watchdog_enable)
		|=> $stable(o_counter_timebase_select)) else $error("timebase moved");
	wd_reset_a: assert property ($fell(i_rst) |-> o_watchdog_enable && !o_irq)
		else $error("reset state");
endmodule // pca_cfg_chk
bind pca_mode_pwm_config pca_cfg_chk #(.CHANNELS(CHANNELS)) chk_u (.i_clk, .i_rst, .i_wr,
	.i_rd, .i_cpu_idle, .o_irq, .o_counter_halt, .o_watchdog_enable, .i_addr, .i_wdata,
	.o_rdata, .i_pwm16, .i_pwm_mode, .o_reload_active, .o_cycle_length_select,
	.o_counter_timebase_select);

// File: testbench/pca_mode_pwm_config_test.sv
/* Self-checking bench for the mode and pwm configuration block.
 Assumes the checker is bound on; the bench drives the register bus itself. */
`timescale 1ns/1ns
`define CK(a, b) begin n_tests++; if ((a) !== (b)) begin num_errors++; \
	$display("BAD %0t got %h exp %h", $time, a, b); end end
module pca_mode_pwm_config_test;
	logic i_clk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, i_cpu_idle = 1'b0;
	logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, o_rdata, rv;
	logic [3:0] i_carry = 4'h0;
	logic [5:0] i_pwm16 = 6'h00, i_pwm_mode = 6'h00, o_reload_active;
	logic o_irq, o_reload_bank_select, o_counter_halt, o_watchdog_enable;
	logic o_counter_wrap_irq_enable;
	logic [1:0] o_cycle_length_select;
	logic [2:0] o_counter_timebase_select;
	logic [31:0] seed = 32'h5f04;
	int num_errors = 0, n_tests = 0, md = 8'h40, pw = 0, w;
	pca_mode_pwm_config dut_u (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_addr(i_addr),
		.i_wr(i_wr),
		.i_wdata(i_wdata),
		.i_rd(i_rd),
		.i_carry(i_carry),
		.i_cpu_idle(i_cpu_idle),
		.i_pwm16(i_pwm16),
		.i_pwm_mode(i_pwm_mode),
		.o_rdata(o_rdata),
		.o_irq(o_irq),
		.o_reload_bank_select(o_reload_bank_select),
		.o_reload_active(o_reload_active),
		.o_cycle_length_select(o_cycle_length_select),
		.o_counter_halt(o_counter_halt),
		.o_watchdog_enable(o_watchdog_enable),
		.o_counter_timebase_select(o_counter_timebase_select),
		.o_counter_wrap_irq_enable(o_counter_wrap_irq_enable)
	);
	initial forever #50 i_clk = ~i_clk;
	// ===================
	// Bus and model tasks
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// An idle edge after each access keeps a strobe from dropping and rising in one step
	task automatic wr(input logic [7:0] a, d);
		i_addr = a;
		i_wdata = d;
		i_wr = 1'b1;
		@(posedge i_clk) #10 i_wr = 1'b0;
		@(posedge i_clk) #10;
	endtask
	task automatic rd(input logic [7:0] a);
		i_addr = a;
		i_rd = 1'b1;
		@(posedge i_clk) #10 i_rd = 1'b0;
		rv = o_rdata;
		@(posedge i_clk) #10;
	endtask
	task automatic pulse(input logic [3:0] c, input logic w_en, input logic [7:0] d);
		i_carry = c;
		i_addr = 8'hdf;
		i_wdata = d;
		i_wr = w_en;
		@(posedge i_clk) #10 i_carry = 4'h0;
		i_wr = 1'b0;
		rd(8'hdf);
	endtask
	task automatic finish_test();
		$display("checks %0d errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial
	begin
		repeat (6) @(posedge i_clk);
		#10 i_rst = 1'b0;
		rd(8'hd9);
		`CK(rv, 8'h40)
		for (int i = 0; i < 24; i++)
		begin
			w = rnd() & 32'hdf;
			i_cpu_idle = w[4];
			md = (md[6] ? md & 8'h8e : w & 8'h8e) | (w & 8'h41);
			wr(8'hd9, 8'(w));
			rd(8'hd9);
			`CK(rv, 8'(md))
			`CK(o_counter_timebase_select, 3'(md >> 1))
			`CK(o_counter_halt, md[7] & w[4])
			`CK(o_counter_wrap_irq_enable, md[0])
		end
		$display("mode test done");
		for (int i = 0; i < 24; i++)
		begin
			w = rnd();
			{i_pwm16, i_pwm_mode} = 12'(w >> 8);
			pw = w & 8'he3;
			wr(8'hdf, 8'(w));
			rd(8'hdf);
			`CK(rv, 8'(pw))
			`CK(o_irq, pw[6] & pw[5])
			`CK(o_reload_bank_select, pw[7])
			`CK(o_cycle_length_select, 2'(pw))
			`CK(o_reload_active, (pw[1:0] == 0) ? 6'h00 : i_pwm_mode & ~i_pwm16)
		end
		$display("pwm test done");
		for (int n = 0; n < 4; n++)
		begin
			wr(8'hdf, 8'(n));
			pulse(4'hf ^ 4'(1 << n), 1'b0, 8'(n));
			`CK(rv[5], 1'b0)
			pulse(4'(1 << n), 1'b0, 8'(n));
			`CK(rv[5], 1'b1)
			`CK(o_irq, 1'b0)
			rd(8'hdf);
			`CK(rv[5], 1'b1)
			pulse(4'(1 << n), 1'b1, 8'(n));
			`CK(rv[5], 1'b1)
			wr(8'hdf, 8'(n));
			rd(8'hdf);
			`CK(rv[5], 1'b0)
		end
		$display("wrap test done");
		wr(8'hd9, 8'h20);
		wr(8'hd9, 8'h00);
		md = (md[6] ? md & 8'h8e : 0) | 8'h60;
		rd(8'hd9);
		`CK(rv, 8'(md))
		`CK(o_watchdog_enable, 1'b1)
		i_rst = 1'b1;
		repeat (2) @(posedge i_clk);
		#10 i_rst = 1'b0;
		rd(8'hd9);
		`CK(rv, 8'h40)
		$display("lock test done");
		finish_test();
	end
endmodule // pca_mode_pwm_config_test
